// ---- cpu_ctl_pkg.sv ----
// shared types and constants for the cpu control instruction unit
package cpu_ctl_pkg;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_RUN  = 6'h01,
        ST_HALT = 6'h02,
        ST_SVC  = 6'h04,
        ST_STOP = 6'h08,
        ST_FAST = 6'h10,
        ST_SLOW = 6'h20
    } ctl_state_t;

    // instructions handed over by the decode stage
    typedef enum logic [4:0] {
        OP_NOP       = 5'h00,
        OP_TLH       = 5'h01,
        OP_TLH_INC   = 5'h02,
        OP_TLL       = 5'h03,
        OP_TLL_INC   = 5'h04,
        OP_HALT      = 5'h05,
        OP_STOP      = 5'h06,
        OP_HALT_SRC  = 5'h07,
        OP_IRQ_EN    = 5'h08,
        OP_HALT_EN   = 5'h09,
        OP_STOP_EN   = 5'h0a,
        OP_FAST      = 5'h0b,
        OP_SLOW      = 5'h0c,
        OP_RD_WAKE_A = 5'h0d,
        OP_RD_WAKE_B = 5'h0e,
        OP_RD_CLK    = 5'h0f,
        OP_IDX_H     = 5'h10,
        OP_IDX_L     = 5'h11,
        OP_DAA       = 5'h12,
        OP_DAA_RX    = 5'h13,
        OP_DAA_HL    = 5'h14
    } ctl_op_t;

    // wishbone byte offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_WAKE   = 4'h4;
    localparam logic [3:0] REG_CTRL   = 4'h8;

    // field positions
    localparam int HALT_SRC_PORTC_BIT = 4;
    localparam int STOP_PORTC_BIT     = 4;
    localparam int STOP_PIN_BIT       = 5;
    localparam int WAKE_PORTC_BIT     = 0;
    localparam int WAKE_PIN_BIT       = 1;
    localparam int WAKE_TIMER_BIT     = 2;
    localparam int WAKE_PREDIV_BIT    = 3;
    localparam int CTRL_BACKUP_BIT    = 0;

    // reset values
    localparam logic [3:0] IRQ_EN_RST   = 4'h0;
    localparam logic [2:0] HALT_EN_RST  = 3'h0;
    localparam logic [1:0] STOP_EN_RST  = 2'h0;
    localparam logic [11:0] INDEX_RST   = 12'h000;

    // decimal adjust constants
    localparam logic [3:0] DAA_ADJ     = 4'h6;
    localparam logic [3:0] DAA_MAX     = 4'h9;
    localparam logic [3:0] DAA_LOW_MAX = 4'h3;

endpackage

// ---- pin_evt_if.sv ----
// synchronised pin level and change carrier
`timescale 1ns/1ps
interface pin_evt_if #(parameter int W = 1);
    logic [W-1:0] level;
    logic [W-1:0] change;
    modport src (output level, output change);
    modport dst (input level, input change);
endinterface

// ---- pin_sync_edge.sv ----
// two-flop synchroniser with change detect
`timescale 1ns/1ps
module pin_sync_edge #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    pin_evt_if.src            evt
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    if (W < 1) begin : g_bad_width
        $error("pin_sync_edge: W must be at least 1");
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign evt.level  = s2_r;
    assign evt.change = s2_r ^ s3_r;
endmodule // pin_sync_edge

// ---- cpu_control_instruction_unit.sv ----
// cpu control, table load, index and decimal adjust execution unit
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// Operation
// RULE1: high table load puts upper table nibble into accumulator and data nibble
// RULE2: low table load puts lower table nibble into accumulator and data nibble
// RULE3: incrementing table loads add one to the table index after storing
// RULE4: halt waits for accepted interrupt, enabled port C change, or enabled wake
// RULE5: interrupt out of halt runs service, return goes back to halt
// RULE6: stop enters stop mode and halts all oscillators until released
// RULE7: program drives all port C lines low before stop
// RULE8: stop ends on wake pin change or port C high, each if enabled
// RULE9: halt source bit 4 lets port C change end halt
// RULE10: interrupt enable write loads four enables from operand bits 0 to 3
// RULE11: halt wake enable write loads enables from operand bits 1 to 3
// RULE12: stop wake enable write loads port C and wake pin enables
// RULE13: fast switch starts fast oscillator first, then selects it
// RULE14: slow switch selects slow clock first, then stops fast oscillator
// RULE15: first status read returns backup, port C cause, group cause
// RULE16: second status read returns pin, timer, stage fifteen, predivider bits
// RULE17: clock status read returns clock select flag in bit 0
// RULE18: index high load takes accumulator and data nibble into high byte
// RULE19: index low load copies data nibble into low index nibble
// RULE20: decimal adjust updates accumulator, carry and optional data nibble
// RULE21: program issues decimal adjust only after an addition
// RULE22: add six for A to F carry clear, or 0 to 3 carry set
// RULE23: reserved operand bits are ignored and leave flags untouched
module cpu_control_instruction_unit
    import cpu_ctl_pkg::*;
#(
    parameter int PC_W = 4
) (
    input  wire logic            CLK,
    input  wire logic            RST_N,
    input  wire logic            WB_CYC_I,
    input  wire logic            WB_STB_I,
    input  wire logic            WB_WE_I,
    input  wire logic [3:0]      WB_ADR_I,
    input  wire logic [3:0]      WB_SEL_I,
    input  wire logic [31:0]     WB_DAT_I,
    output logic      [31:0]     WB_DAT_O,
    output logic                 WB_ACK_O,
    input  wire logic            OP_VALID,
    input  wire ctl_op_t         OP_CODE,
    input  wire logic [7:0]      OP_X,
    output logic                 OP_READY,
    input  wire logic [7:0]      TBL_WORD,
    input  wire logic [3:0]      RX_NIBBLE,
    input  wire logic [3:0]      ACC_IN,
    input  wire logic            CARRY_IN,
    output logic      [3:0]      ACC_OUT,
    output logic                 ACC_WE,
    output logic                 CARRY_OUT,
    output logic                 CARRY_WE,
    output logic      [3:0]      MEM_DATA,
    output logic                 MEM_WE,
    output logic                 MEM_AT_INDEX,
    output logic      [11:0]     INDEX_PTR,
    input  wire logic [PC_W-1:0] PORT_C_LINES,
    input  wire logic            WAKE_PIN,
    input  wire logic            TIMER_ONE_UFL,
    input  wire logic            PREDIV_OVF,
    input  wire logic            PREDIV_STAGE15,
    output logic                 IRQ_REQ,
    output logic      [1:0]      IRQ_ID,
    input  wire logic            IRQ_ACK,
    input  wire logic            RTS_DONE,
    output logic                 FAST_OSC_EN,
    input  wire logic            FAST_OSC_READY,
    output logic                 CLK_SELECT_FAST,
    output logic                 ALL_OSC_STOP,
    output logic                 HALTED
);
    if (PC_W < 1 || PC_W > 8) begin : g_bad_pc_w
        $error("cpu_control_instruction_unit: PC_W must be 1 to 8");
    end

    ctl_state_t  state_r, state_nxt;
    logic [11:0] idx_r, idx_nxt;
    logic [3:0]  acc_r, mem_r;
    logic        acc_we_r, mem_we_r, at_idx_r, carry_r, carry_we_r;
    logic        sca_portc_r;
    logic [3:0]  irq_en_r, pend_r;
    logic [2:0]  halt_en_r;
    logic [1:0]  stop_en_r;
    logic        fast_en_r, clk_sel_r, backup_r;
    logic [3:0]  wake_r, wake_set, wake_clr;
    logic        ack_r;
    logic [31:0] dat_r;

    pin_evt_if #(.W(PC_W)) pc_evt ();
    pin_evt_if #(.W(1))    wp_evt ();
    pin_evt_if #(.W(1))    rdy_evt ();

    pin_sync_edge #(.W(PC_W)) u_pc_sync (
        .clk    (CLK),
        .rst_n  (RST_N),
        .pin_in (PORT_C_LINES),
        .evt    (pc_evt)
    );
    pin_sync_edge #(.W(1)) u_wp_sync (
        .clk    (CLK),
        .rst_n  (RST_N),
        .pin_in (WAKE_PIN),
        .evt    (wp_evt)
    );
    pin_sync_edge #(.W(1)) u_rdy_sync (
        .clk    (CLK),
        .rst_n  (RST_N),
        .pin_in (FAST_OSC_READY),
        .evt    (rdy_evt)
    );

    // instruction decode
    wire op_take  = OP_VALID && OP_READY;
    wire is_tlh   = (OP_CODE == OP_TLH) || (OP_CODE == OP_TLH_INC);
    wire is_tll   = (OP_CODE == OP_TLL) || (OP_CODE == OP_TLL_INC);
    wire is_inc   = (OP_CODE == OP_TLH_INC) || (OP_CODE == OP_TLL_INC);
    wire is_rd    = (OP_CODE == OP_RD_WAKE_A) || (OP_CODE == OP_RD_WAKE_B)
                 || (OP_CODE == OP_RD_CLK);
    wire is_daa_m = (OP_CODE == OP_DAA_RX) || (OP_CODE == OP_DAA_HL);
    wire is_daa   = (OP_CODE == OP_DAA) || is_daa_m;
    wire do_acc   = op_take && (is_tlh || is_tll || is_rd || is_daa);
    wire do_mem   = op_take && (is_tlh || is_tll || is_rd || is_daa_m);

    // events
    wire pc_chg   = |pc_evt.change;
    wire pc_high  = |pc_evt.level;
    wire pin_chg  = wp_evt.change[0];
    wire osc_rdy  = rdy_evt.level[0];

    // decimal adjust after addition
    wire daa_hi   = !CARRY_IN && (ACC_IN > DAA_MAX);            // RULE22
    wire daa_lo   = CARRY_IN && (ACC_IN <= DAA_LOW_MAX);        // RULE22
    wire [3:0] daa_val = (daa_hi || daa_lo) ? 4'(ACC_IN + DAA_ADJ) : ACC_IN;
    wire daa_cy   = daa_hi ? 1'b1 : CARRY_IN;                   // RULE20

    // status words read by instructions
    wire wake_grp = wake_r[WAKE_PIN_BIT] | wake_r[WAKE_TIMER_BIT] | wake_r[WAKE_PREDIV_BIT];
    wire [3:0] stat_a = {1'b0, wake_grp, wake_r[WAKE_PORTC_BIT], backup_r};  // RULE15
    wire [3:0] stat_b = {wake_r[WAKE_PREDIV_BIT], PREDIV_STAGE15,
                         wake_r[WAKE_TIMER_BIT], wake_r[WAKE_PIN_BIT]};      // RULE16
    wire [3:0] stat_c = {3'b000, clk_sel_r};                                  // RULE17

    wire [3:0] res_val =
        is_tlh                        ? TBL_WORD[7:4] :                      // RULE1
        is_tll                        ? TBL_WORD[3:0] :                      // RULE2
        (OP_CODE == OP_RD_WAKE_A)     ? stat_a :
        (OP_CODE == OP_RD_WAKE_B)     ? stat_b :
        (OP_CODE == OP_RD_CLK)        ? stat_c : daa_val;

    // index register
    assign idx_nxt =
        (op_take && OP_CODE == OP_IDX_H) ? {ACC_IN, RX_NIBBLE, idx_r[3:0]} : // RULE18
        (op_take && OP_CODE == OP_IDX_L) ? {idx_r[11:4], RX_NIBBLE} :        // RULE19
        (op_take && is_inc)              ? 12'(idx_r + 12'h001) : idx_r;     // RULE3

    // halt and stop release conditions
    wire hw_portc  = sca_portc_r & pc_chg;                      // RULE9
    wire hw_timer  = halt_en_r[0] & TIMER_ONE_UFL;              // RULE11
    wire hw_pin    = halt_en_r[1] & pin_chg;
    wire hw_prediv = halt_en_r[2] & PREDIV_OVF;
    wire halt_wake = hw_portc | hw_timer | hw_pin | hw_prediv;  // RULE4
    wire sw_pin    = stop_en_r[1] & pin_chg;                    // RULE8
    wire sw_portc  = stop_en_r[0] & pc_high;                    // RULE8
    wire stop_wake = sw_pin | sw_portc;                         // RULE8
    wire in_halt   = (state_r == ST_HALT);
    wire in_stop   = (state_r == ST_STOP);

    assign wake_set[WAKE_PORTC_BIT]  = (in_halt && hw_portc) || (in_stop && sw_portc);
    assign wake_set[WAKE_PIN_BIT]    = (in_halt && hw_pin) || (in_stop && sw_pin);
    assign wake_set[WAKE_TIMER_BIT]  = in_halt && hw_timer;
    assign wake_set[WAKE_PREDIV_BIT] = in_halt && hw_prediv;

    // interrupt pending, lowest source first
    wire [3:0] irq_evt = {PREDIV_OVF, pin_chg, TIMER_ONE_UFL, pc_chg} & irq_en_r;
    wire [3:0] low_bit = pend_r & 4'(~pend_r + 4'h1);
    wire [3:0] ack_msk = IRQ_ACK ? low_bit : 4'h0;
    assign IRQ_REQ = |pend_r;
    assign IRQ_ID  = low_bit[0] ? 2'h0 : low_bit[1] ? 2'h1 : low_bit[2] ? 2'h2 : 2'h3;

    // sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN, ST_SVC: begin
                if (state_r == ST_SVC && RTS_DONE) begin
                    state_nxt = ST_HALT;                        // RULE5
                end else if (op_take) begin
                    case (OP_CODE)
                        OP_HALT: state_nxt = ST_HALT;           // RULE4
                        OP_STOP: state_nxt = ST_STOP;           // RULE6
                        OP_FAST: state_nxt = ST_FAST;           // RULE13
                        OP_SLOW: state_nxt = ST_SLOW;           // RULE14
                        default: state_nxt = state_r;
                    endcase
                end
            end
            ST_HALT: begin
                if (IRQ_ACK) begin
                    state_nxt = ST_SVC;                         // RULE5
                end else if (halt_wake) begin
                    state_nxt = ST_RUN;                         // RULE4
                end
            end
            ST_STOP: begin
                if (stop_wake) begin
                    state_nxt = ST_RUN;                         // RULE8
                end
            end
            ST_FAST: begin
                if (osc_rdy) begin
                    state_nxt = ST_RUN;                         // RULE13
                end
            end
            ST_SLOW: state_nxt = ST_RUN;                        // RULE14
            default: state_nxt = ST_RUN;
        endcase
    end

    assign OP_READY     = (state_r == ST_RUN) || (state_r == ST_SVC);
    assign ALL_OSC_STOP = in_stop;                              // RULE6
    assign HALTED       = in_halt;

    // wishbone slave, ack one cycle after the strobe, write at the ack edge
    wire wb_req = WB_CYC_I && WB_STB_I;
    wire wb_wr  = wb_req && WB_WE_I && ack_r && WB_SEL_I[0];
    wire [31:0] status_w = {14'h0, stop_en_r, sca_portc_r, halt_en_r, irq_en_r,
                            fast_en_r, clk_sel_r, state_r};
    wire [31:0] rd_mux =
        (WB_ADR_I == REG_STATUS) ? status_w :
        (WB_ADR_I == REG_WAKE)   ? {28'h0, wake_r} :
        (WB_ADR_I == REG_CTRL)   ? {31'h0, backup_r} : 32'h0;
    assign wake_clr = (wb_wr && WB_ADR_I == REG_WAKE) ? WB_DAT_I[3:0] : 4'h0;
    wire ctrl_wr = wb_wr && (WB_ADR_I == REG_CTRL);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= wb_req && !ack_r;
            dat_r <= (wb_req && !ack_r) ? rd_mux : dat_r;
        end
    end
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;

    // execution results
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r    <= ST_RUN;
            idx_r      <= INDEX_RST;
            acc_r      <= 4'h0;
            mem_r      <= 4'h0;
            acc_we_r   <= 1'b0;
            mem_we_r   <= 1'b0;
            at_idx_r   <= 1'b0;
            carry_r    <= 1'b0;
            carry_we_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            idx_r      <= idx_nxt;
            acc_r      <= do_acc ? res_val : acc_r;
            mem_r      <= do_mem ? res_val : mem_r;
            acc_we_r   <= do_acc;                               // RULE20
            mem_we_r   <= do_mem;
            at_idx_r   <= op_take && (OP_CODE == OP_DAA_HL);
            carry_r    <= (op_take && is_daa) ? daa_cy : carry_r;
            carry_we_r <= op_take && is_daa;
        end
    end

    // enable flags, only defined operand bits are loaded
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sca_portc_r <= 1'b0;
            irq_en_r    <= IRQ_EN_RST;
            halt_en_r   <= HALT_EN_RST;
            stop_en_r   <= STOP_EN_RST;
        end else if (op_take) begin
            if (OP_CODE == OP_HALT_SRC) begin
                sca_portc_r <= OP_X[HALT_SRC_PORTC_BIT];        // RULE23
            end
            if (OP_CODE == OP_IRQ_EN) begin
                irq_en_r <= OP_X[3:0];                          // RULE10
            end
            if (OP_CODE == OP_HALT_EN) begin
                halt_en_r <= OP_X[3:1];                         // RULE11
            end
            if (OP_CODE == OP_STOP_EN) begin
                stop_en_r <= {OP_X[STOP_PIN_BIT], OP_X[STOP_PORTC_BIT]};  // RULE12
            end
        end
    end

    // clock control, interrupt pending, wake causes and backup
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fast_en_r <= 1'b0;
            clk_sel_r <= 1'b0;
            pend_r    <= 4'h0;
            wake_r    <= 4'h0;
            backup_r  <= 1'b0;
        end else begin
            if (op_take && OP_CODE == OP_FAST) begin
                fast_en_r <= 1'b1;                              // RULE13
            end else if (state_r == ST_SLOW) begin
                fast_en_r <= 1'b0;                              // RULE14
            end
            if (state_r == ST_FAST && osc_rdy) begin
                clk_sel_r <= 1'b1;                              // RULE13
            end else if (op_take && OP_CODE == OP_SLOW) begin
                clk_sel_r <= 1'b0;                              // RULE14
            end
            pend_r   <= (pend_r & ~ack_msk) | irq_evt;
            wake_r   <= (wake_r & ~wake_clr) | wake_set;
            backup_r <= ctrl_wr ? WB_DAT_I[CTRL_BACKUP_BIT] : backup_r;
        end
    end

    assign ACC_OUT         = acc_r;
    assign ACC_WE          = acc_we_r;
    assign MEM_DATA        = mem_r;
    assign MEM_WE          = mem_we_r;
    assign MEM_AT_INDEX    = at_idx_r;
    assign CARRY_OUT       = carry_r;
    assign CARRY_WE        = carry_we_r;
    assign INDEX_PTR       = idx_r;
    assign FAST_OSC_EN     = fast_en_r;
    assign CLK_SELECT_FAST = clk_sel_r;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_take(ctl_op_t o);
        op_take && (OP_CODE == o);
    endsequence

    sequence s_svc_ret;
        (state_r == ST_SVC) && RTS_DONE;
    endsequence

    a_table_high: assert property (op_take && is_tlh |=> ACC_WE && MEM_WE
        && ACC_OUT == $past(TBL_WORD[7:4])) else $error("high table load wrong"); // RULE1
    a_table_low: assert property (s_take(OP_TLL_INC) |=> MEM_WE
        && MEM_DATA == $past(TBL_WORD[3:0])) else $error("low table load wrong"); // RULE2
    a_index_inc: assert property (op_take && is_inc |=>
        INDEX_PTR == 12'($past(INDEX_PTR) + 12'h001)) else $error("index not bumped"); // RULE3
    a_halt_holds: assert property (in_halt && !IRQ_ACK && !halt_wake |=> in_halt)
        else $error("halt left without cause"); // RULE4
    a_svc_enter: assert property (in_halt && IRQ_ACK |=> state_r == ST_SVC)
        else $error("accepted interrupt did not start service"); // RULE5
    a_svc_return: assert property (s_svc_ret |=> in_halt)
        else $error("no return to halt"); // RULE5
    a_stop_osc: assert property (s_take(OP_STOP) |=> ALL_OSC_STOP && !OP_READY)
        else $error("stop did not halt oscillators"); // RULE6
    a_stop_wake: assert property (in_stop && stop_wake |=> state_r == ST_RUN)
        else $error("stop not released"); // RULE8
    a_irq_load: assert property (s_take(OP_IRQ_EN) |=> irq_en_r == $past(OP_X[3:0]))
        else $error("interrupt enables wrong"); // RULE10
    a_fast_order: assert property ($rose(CLK_SELECT_FAST) |-> $past(FAST_OSC_EN))
        else $error("fast clock selected before start"); // RULE13
    a_slow_order: assert property ($fell(FAST_OSC_EN) |-> !CLK_SELECT_FAST
        && !$past(CLK_SELECT_FAST)) else $error("fast osc stopped while selected"); // RULE14
    a_daa_high: assert property (s_take(OP_DAA) && daa_hi |=> CARRY_WE && CARRY_OUT
        && ACC_OUT == 4'($past(ACC_IN) + 4'h6)) else $error("decimal adjust wrong"); // RULE22
endmodule // cpu_control_instruction_unit

// ---- decode_model.sv ----
// behavioural decode stage that offers instructions and table words
`timescale 1ns/1ps
module decode_model
    import cpu_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        op_ready,
    input  wire logic [11:0] index_ptr,
    output logic             op_valid,
    output ctl_op_t          op_code,
    output logic      [7:0]  op_x,
    output logic      [7:0]  tbl_word,
    output logic      [3:0]  rx,
    output logic      [3:0]  acc,
    output logic             cf
);
    // table word follows the pointer so a stale pointer shows up
    assign tbl_word = {~index_ptr[3:0], index_ptr[3:0]};
    initial begin
        op_valid = 1'b0;
        op_code  = OP_NOP;
        op_x     = 8'h00;
        rx       = 4'h0;
        acc      = 4'h0;
        cf       = 1'b0;
    end
    task automatic issue(input ctl_op_t o, input logic [7:0] x, input logic [3:0] r,
                         input logic [3:0] a, input logic c);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code  <= o;
        op_x     <= x;
        rx       <= r;
        acc      <= a;
        cf       <= c;
        @(negedge clk);
        while (op_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        op_valid <= 1'b0;
    endtask
endmodule // decode_model

// ---- tb_cpu_control_instruction_unit.sv ----
// self-checking bench for the cpu control instruction unit
`timescale 1ns/1ps
module tb_cpu_control_instruction_unit;
    import cpu_ctl_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, pc = 4'h0;
    logic [31:0] wd = 32'h0, rd, q;
    logic        ack, wpin = 1'b0, tufl = 1'b0, povf = 1'b0, st15 = 1'b1;
    logic        iack = 1'b0, rts = 1'b0, frdy = 1'b0, irq_req, fen, clock_select_flag, astop, halted;
    logic [1:0]  irq_id;
    logic [3:0]  acc_o, mem_d, rx, acc;
    logic        acc_we, cf_o, cf_we, mem_we, mem_ix, opv, rdy, cf;
    logic [11:0] idx;
    logic [7:0]  opx, tw;
    ctl_op_t     opc;
    int          errors = 0, n_tests = 0, cycles = 0;
    ctl_op_t     da_op[4] = '{OP_DAA, OP_DAA_RX, OP_DAA_HL, OP_DAA};
    logic [3:0]  da_a[4] = '{4'ha, 4'h2, 4'h5, 4'hf}, da_r[4] = '{4'h0, 4'h8, 4'h5, 4'h5};
    logic [1:0]  da_c[4] = '{2'b01, 2'b11, 2'b00, 2'b01};
    logic [1:0]  da_m[4] = '{2'b00, 2'b10, 2'b11, 2'b00};

    always #50 clk = ~clk;

    cpu_control_instruction_unit #(.PC_W(4)) dut (
        .CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
        .OP_VALID(opv), .OP_CODE(opc), .OP_X(opx), .OP_READY(rdy), .TBL_WORD(tw),
        .RX_NIBBLE(rx), .ACC_IN(acc), .CARRY_IN(cf), .ACC_OUT(acc_o), .ACC_WE(acc_we),
        .CARRY_OUT(cf_o), .CARRY_WE(cf_we), .MEM_DATA(mem_d), .MEM_WE(mem_we),
        .MEM_AT_INDEX(mem_ix), .INDEX_PTR(idx), .PORT_C_LINES(pc), .WAKE_PIN(wpin),
        .TIMER_ONE_UFL(tufl), .PREDIV_OVF(povf), .PREDIV_STAGE15(st15),
        .IRQ_REQ(irq_req), .IRQ_ID(irq_id), .IRQ_ACK(iack), .RTS_DONE(rts),
        .FAST_OSC_EN(fen), .FAST_OSC_READY(frdy), .CLK_SELECT_FAST(clock_select_flag),
        .ALL_OSC_STOP(astop), .HALTED(halted));

    decode_model m (.clk(clk), .op_ready(rdy), .index_ptr(idx), .op_valid(opv),
        .op_code(opc), .op_x(opx), .tbl_word(tw), .rx(rx), .acc(acc), .cf(cf));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        wd  <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic run(input ctl_op_t o, input logic [7:0] x, input logic [3:0] r,
                       input logic [3:0] a, input logic c);
        m.issue(o, x, r, a, c);
        @(negedge clk);
    endtask
    task automatic pulse(input logic [2:0] sel);
        @(posedge clk);
        {rts, iack, tufl} <= sel;
        @(posedge clk);
        {rts, iack, tufl} <= 3'h0;
        repeat (6) @(negedge clk);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, REG_STATUS, 32'h0);
        chk(q, 32'h1);
        wb(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
        run(OP_IDX_L, 8'h00, 4'h3, 4'h0, 1'b0);
        chk(idx, 12'h003);
        run(OP_IDX_H, 8'h00, 4'h2, 4'h1, 1'b0);
        chk(idx, 12'h123);
        run(OP_TLH_INC, 8'h00, 4'h0, 4'h0, 1'b0);
        chk({acc_o, mem_d, acc_we, mem_we, idx}, {4'hc, 4'hc, 2'b11, 12'h124});
        run(OP_TLL, 8'h00, 4'h0, 4'h0, 1'b0);
        chk({acc_o, mem_d, acc_we, mem_we, idx}, {4'h4, 4'h4, 2'b11, 12'h124});
        run(OP_TLL_INC, 8'h00, 4'h0, 4'h0, 1'b0);
        chk({acc_o, idx}, {4'h4, 12'h125});
        $display("test table loads done");
        // stimulus only adjusts results of additions
        for (int i = 0; i < 4; i++) begin
            run(da_op[i], 8'h00, 4'h0, da_a[i], da_c[i][1]);
            chk({acc_o, cf_o, acc_we, cf_we, mem_we}, {da_r[i], da_c[i][0], 2'b11, da_m[i][1]});
            if (da_m[i][1]) chk(mem_ix, da_m[i][0]);
        end
        $display("test decimal adjust done");
        run(OP_IRQ_EN, 8'hf2, 4'h0, 4'h0, 1'b0);
        run(OP_HALT_EN, 8'hf5, 4'h0, 4'h0, 1'b0);
        run(OP_HALT_SRC, 8'hef, 4'h0, 4'h0, 1'b0);
        run(OP_STOP_EN, 8'hdf, 4'h0, 4'h0, 1'b0);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(q, 32'h12201);
        $display("test enables done");
        run(OP_HALT, 8'h00, 4'h0, 4'h0, 1'b0);
        chk(halted, 1'b1);
        pulse(3'h1);
        chk({halted, irq_req, irq_id}, 4'b1101);
        pulse(3'h2);
        chk(halted, 1'b0);
        pulse(3'h4);
        chk(halted, 1'b1);
        @(posedge clk) wpin <= 1'b1;
        repeat (6) @(negedge clk);
        chk(halted, 1'b0);
        wb(1'b0, REG_WAKE, 32'h0);
        chk(q, 32'h2);
        run(OP_RD_WAKE_B, 8'h00, 4'h0, 4'h0, 1'b0);
        chk({acc_o, mem_d, mem_we}, {4'h5, 4'h5, 1'b1});
        run(OP_RD_WAKE_A, 8'h00, 4'h0, 4'h0, 1'b0);
        chk({acc_o, mem_d}, 8'h44);
        wb(1'b1, REG_WAKE, 32'hf);
        wb(1'b1, REG_CTRL, 32'h1);
        run(OP_RD_WAKE_A, 8'h00, 4'h0, 4'h0, 1'b0);
        chk(acc_o, 4'h1);
        $display("test halt done");
        @(posedge clk) pc <= 4'h0;
        run(OP_STOP, 8'h00, 4'h0, 4'h0, 1'b0);
        chk(astop, 1'b1);
        @(posedge clk) wpin <= 1'b0;
        repeat (6) @(negedge clk);
        chk(astop, 1'b1);
        @(posedge clk) pc <= 4'h4;
        repeat (6) @(negedge clk);
        chk(astop, 1'b0);
        $display("test stop done");
        run(OP_HALT_SRC, 8'h10, 4'h0, 4'h0, 1'b0);
        run(OP_HALT, 8'h00, 4'h0, 4'h0, 1'b0);
        chk(halted, 1'b1);
        @(posedge clk) pc <= 4'h0;
        repeat (6) @(negedge clk);
        chk(halted, 1'b0);
        $display("test halt port release done");
        run(OP_FAST, 8'h00, 4'h0, 4'h0, 1'b0);
        chk({fen, clock_select_flag}, 2'b10);
        @(posedge clk) frdy <= 1'b1;
        repeat (6) @(negedge clk);
        chk({fen, clock_select_flag}, 2'b11);
        run(OP_RD_CLK, 8'h00, 4'h0, 4'h0, 1'b0);
        chk({acc_o, mem_d}, 8'h11);
        run(OP_SLOW, 8'h00, 4'h0, 4'h0, 1'b0);
        chk({fen, clock_select_flag}, 2'b10);
        @(negedge clk);
        chk({fen, clock_select_flag}, 2'b00);
        $display("test clock switch done");
        give_verdict();
    end
endmodule // tb_cpu_control_instruction_unit
